// ### shared/sebk_map.vh
// Purpose: constants of the status event register bank
// Assumes: included by bare name from the rtl files
// Notes: definitions only
`ifndef SEBK_MAP_VH
`define SEBK_MAP_VH

// Register select codes on the command port
`define SEBK_SEL_W 3
`define SEBK_SEL_OPER_EV 3'h0
`define SEBK_SEL_TRIG_EV 3'h1
`define SEBK_SEL_ARM_EV 3'h2
`define SEBK_SEL_SEQ_EV 3'h3
`define SEBK_SEL_OPER_EN 3'h4
`define SEBK_SEL_TRIG_EN 3'h5
`define SEBK_SEL_ARM_EN 3'h6
`define SEBK_SEL_SEQ_EN 3'h7

// Field positions in the operation event register
`define SEBK_OPER_SETTLE_BIT 1
`define SEBK_OPER_TRIG_BIT 5
`define SEBK_OPER_ARM_BIT 6
`define SEBK_OPER_IDLE_BIT 10

// Field positions in the trigger, arm and sequence event registers
`define SEBK_TRIG_SEQUENCE_ONE_FLAG_BIT 1
`define SEBK_ARM_SEQUENCE_ONE_FLAG_BIT 1
`define SEBK_SEQ_LAYER_ONE_FLAG_BIT 1
`define SEBK_SEQ_LAYER_TWO_FLAG_BIT 2

// Bits that exist in each register; all others read as zero
`define SEBK_OPER_USED 16'h0462
`define SEBK_TRIG_USED 16'h0002
`define SEBK_ARM_USED 16'h0002
`define SEBK_SEQ_USED 16'h0006

// Reset values
`define SEBK_EVENT_RST 16'h0000
`define SEBK_ENABLE_RST 16'h0000

`endif

// ### rtl/sebk_edge_latch.v
// Purpose: one event register with transition filter and summary
// Assumes: condition levels synchronous to mclk
// Notes: unused bits are held at zero by the used mask
`timescale 1ns/100ps
module sebk_edge_latch #(
	parameter WIDTH = 16,
	parameter [15:0] USED = 16'hffff
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire [WIDTH-1:0] cond,
	input wire [WIDTH-1:0] rise_sel,
	input wire [WIDTH-1:0] fall_sel,
	input wire [WIDTH-1:0] enable,
	input wire clear,
	output wire [WIDTH-1:0] event_bits,
	output wire summary
);
	reg [WIDTH-1:0] prev_r;
	reg primed_r;
	reg [WIDTH-1:0] event_r;
	wire [WIDTH-1:0] rise_hit;
	wire [WIDTH-1:0] fall_hit;
	wire [WIDTH-1:0] event_nxt;

	assign rise_hit = cond & ~prev_r & rise_sel;
	assign fall_hit = ~cond & prev_r & fall_sel;
	// Clear, but a same-cycle edge still lands
	assign event_nxt = ((clear ? {WIDTH{1'b0}} : event_r)
		| ({WIDTH{primed_r}} & (rise_hit | fall_hit))) & USED[WIDTH-1:0];

	// First cycle after reset only samples, so a level is not an edge
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			prev_r <= {WIDTH{1'b0}};
			primed_r <= 1'b0;
			event_r <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			prev_r <= cond;
			primed_r <= 1'b1;
			event_r <= event_nxt;
		end
	end

	assign event_bits = event_r;
	// Masked bits cannot raise the summary
	// Enabled set bit raises the summary
	assign summary = |(event_r & enable);
endmodule

// ### rtl/sebk_enable_reg.v
// Purpose: one event enable mask register
// Assumes: write and preset are single-cycle strobes
// Notes: bits that do not exist always read zero
`timescale 1ns/100ps
`include "sebk_map.vh"
module sebk_enable_reg #(
	parameter WIDTH = 16,
	parameter [15:0] USED = 16'hffff
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire wr,
	input wire [WIDTH-1:0] wdata,
	input wire preset,
	output wire [WIDTH-1:0] mask
);
	reg [WIDTH-1:0] mask_r;

	// Zero at reset and preset, host value on write, held otherwise
	always @(posedge mclk)
	begin
		if (!rst_n)
			mask_r <= `SEBK_ENABLE_RST;
		else if (ce)
		begin
			if (preset)
				mask_r <= `SEBK_ENABLE_RST;
			else if (wr)
				mask_r <= wdata & USED[WIDTH-1:0];
		end
	end

	assign mask = mask_r;
endmodule

// ### rtl/sebk_status_bank.v
// Purpose: status event register bank: four event registers and masks
// Assumes: one clock, synchronous inputs, host command port one per cycle
// Notes: values are returned as plain binary; text formatting is outside
// How it works
// - Event read returns the register value, each set bit marking one event.
// - Reading an event register clears it after the value is returned.
// - Rising-selected bit sets when its condition goes false to true.
// - Falling-selected bit sets when its condition goes true to false.
// - Operation bit 1 follows relay settling entry or expiry.
// - Operation bit 5 follows waiting in the trigger layer.
// - Operation bit 6 follows waiting in an arm layer.
// - Operation bit 10 follows the idle state.
// - All other operation bits never set.
// - Trigger register uses only bit 1, trigger layer presence.
// - Arm register uses only bit 1, arm layer presence.
// - Sequence register bit 1 is arm layer one, bit 2 layer two.
// - Enable bit zero masks the event from the summary.
// - Enabled set event raises the next level summary bit.
// - Enables clear at reset and preset, not on clear status.
// - Enable read returns its contents as the bit pattern.
`timescale 1ns/100ps
`include "sebk_map.vh"
module sebk_status_bank #(
	parameter WIDTH = 16
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	// Instrument state levels
	input wire cond_settling,
	input wire cond_trig_wait,
	input wire cond_arm_wait,
	input wire cond_idle,
	input wire sequence_one_flag,
	input wire arm_sequence_flag,
	input wire layer_one_flag,
	input wire layer_two_flag,
	// Transition selections per register
	input wire [WIDTH-1:0] oper_rise_select,
	input wire [WIDTH-1:0] oper_falling_edge_select,
	input wire [WIDTH-1:0] trig_rise_select,
	input wire [WIDTH-1:0] trig_falling_edge_select,
	input wire [WIDTH-1:0] arm_rise_select,
	input wire [WIDTH-1:0] arm_falling_edge_select,
	input wire [WIDTH-1:0] seq_rise_select,
	input wire [WIDTH-1:0] seq_falling_edge_select,
	// Common commands
	input wire clear_status,
	input wire status_preset,
	// Host command port
	input wire cmd_valid,
	input wire cmd_write,
	input wire [2:0] cmd_sel,
	input wire [WIDTH-1:0] cmd_wdata,
	output wire rsp_valid,
	output wire rsp_error,
	output wire [WIDTH-1:0] rsp_data,
	// Summary bits into the next status level
	output wire oper_summary,
	output wire trig_summary,
	output wire arm_summary,
	output wire seq_summary
);
	// Command decode
	wire cmd_take;
	wire is_event_sel;
	wire rd_take;
	wire wr_take;
	wire wr_bad;
	reg [7:0] sel_hot;

	// Condition levels placed on their bit weights
	reg [WIDTH-1:0] oper_cond;
	reg [WIDTH-1:0] trig_cond;
	reg [WIDTH-1:0] arm_cond;
	reg [WIDTH-1:0] seq_cond;

	// Register contents
	wire [WIDTH-1:0] oper_ev;
	wire [WIDTH-1:0] trig_ev;
	wire [WIDTH-1:0] arm_ev;
	wire [WIDTH-1:0] seq_ev;
	wire [WIDTH-1:0] oper_en;
	wire [WIDTH-1:0] trig_en;
	wire [WIDTH-1:0] arm_en;
	wire [WIDTH-1:0] seq_en;

	// Clear and write strobes per register
	wire oper_clr;
	wire trig_clr;
	wire arm_clr;
	wire seq_clr;
	wire oper_en_wr;
	wire trig_en_wr;
	wire arm_en_wr;
	wire seq_en_wr;

	// Read path and response
	wire [WIDTH-1:0] rd_mux;
	reg [WIDTH-1:0] ev_mux;
	reg [WIDTH-1:0] en_mux;
	reg [WIDTH-1:0] rsp_data_r;
	reg rsp_valid_r;
	reg rsp_error_r;

	// Command acceptance; the port never stalls
	assign cmd_take = cmd_valid & ce;
	assign is_event_sel = ~cmd_sel[2];
	assign rd_take = cmd_take & ~cmd_write;
	assign wr_take = cmd_take & cmd_write & ~is_event_sel;
	// Event registers are read-only; a write to one is refused
	assign wr_bad = cmd_take & cmd_write & is_event_sel;

	// One-hot select; a single decode feeds every clear and write strobe
	always @*
	begin
		sel_hot = 8'h00;
		case (cmd_sel)
			`SEBK_SEL_OPER_EV: sel_hot = 8'h01;
			`SEBK_SEL_TRIG_EV: sel_hot = 8'h02;
			`SEBK_SEL_ARM_EV: sel_hot = 8'h04;
			`SEBK_SEL_SEQ_EV: sel_hot = 8'h08;
			`SEBK_SEL_OPER_EN: sel_hot = 8'h10;
			`SEBK_SEL_TRIG_EN: sel_hot = 8'h20;
			`SEBK_SEL_ARM_EN: sel_hot = 8'h40;
			`SEBK_SEL_SEQ_EN: sel_hot = 8'h80;
			default: sel_hot = 8'h00;
		endcase
	end

	// Each level sits on its own weight; every unused position stays low
	always @*
	begin
		oper_cond = {WIDTH{1'b0}};
		trig_cond = {WIDTH{1'b0}};
		arm_cond = {WIDTH{1'b0}};
		seq_cond = {WIDTH{1'b0}};
		oper_cond[`SEBK_OPER_SETTLE_BIT] = cond_settling;
		// Trigger wait on operation bit 5
		oper_cond[`SEBK_OPER_TRIG_BIT] = cond_trig_wait;
		// Arm wait on operation bit 6
		oper_cond[`SEBK_OPER_ARM_BIT] = cond_arm_wait;
		oper_cond[`SEBK_OPER_IDLE_BIT] = cond_idle;
		// Trigger layer presence on bit 1
		trig_cond[`SEBK_TRIG_SEQUENCE_ONE_FLAG_BIT] = sequence_one_flag;
		// Arm layer presence on bit 1
		arm_cond[`SEBK_ARM_SEQUENCE_ONE_FLAG_BIT] = arm_sequence_flag;
		// Arm layer one on bit 1, layer two on bit 2
		seq_cond[`SEBK_SEQ_LAYER_ONE_FLAG_BIT] = layer_one_flag;
		seq_cond[`SEBK_SEQ_LAYER_TWO_FLAG_BIT] = layer_two_flag;
	end

	// Read of a register, or clear status, empties it
	assign oper_clr = clear_status | (rd_take & sel_hot[0]);
	assign trig_clr = clear_status | (rd_take & sel_hot[1]);
	assign arm_clr = clear_status | (rd_take & sel_hot[2]);
	assign seq_clr = clear_status | (rd_take & sel_hot[3]);

	// Host value is the mask itself, zero clears all
	assign oper_en_wr = wr_take & sel_hot[4];
	assign trig_en_wr = wr_take & sel_hot[5];
	assign arm_en_wr = wr_take & sel_hot[6];
	assign seq_en_wr = wr_take & sel_hot[7];

	// Operation event register
	// Used mask keeps unused operation bits at zero
	sebk_edge_latch #(
		.WIDTH(WIDTH),
		.USED(`SEBK_OPER_USED)
	) u_oper_ev (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.cond(oper_cond),
		.rise_sel(oper_rise_select),
		.fall_sel(oper_falling_edge_select),
		.enable(oper_en),
		.clear(oper_clr),
		.event_bits(oper_ev),
		.summary(oper_summary)
	);

	// Trigger event register
	sebk_edge_latch #(
		.WIDTH(WIDTH),
		.USED(`SEBK_TRIG_USED)
	) u_trig_ev (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.cond(trig_cond),
		.rise_sel(trig_rise_select),
		.fall_sel(trig_falling_edge_select),
		.enable(trig_en),
		.clear(trig_clr),
		.event_bits(trig_ev),
		.summary(trig_summary)
	);

	// Arm event register
	sebk_edge_latch #(
		.WIDTH(WIDTH),
		.USED(`SEBK_ARM_USED)
	) u_arm_ev (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.cond(arm_cond),
		.rise_sel(arm_rise_select),
		.fall_sel(arm_falling_edge_select),
		.enable(arm_en),
		.clear(arm_clr),
		.event_bits(arm_ev),
		.summary(arm_summary)
	);

	// Sequence event register
	sebk_edge_latch #(
		.WIDTH(WIDTH),
		.USED(`SEBK_SEQ_USED)
	) u_seq_ev (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.cond(seq_cond),
		.rise_sel(seq_rise_select),
		.fall_sel(seq_falling_edge_select),
		.enable(seq_en),
		.clear(seq_clr),
		.event_bits(seq_ev),
		.summary(seq_summary)
	);

	// Enable masks; preset clears, clear status does not reach them
	sebk_enable_reg #(
		.WIDTH(WIDTH),
		.USED(`SEBK_OPER_USED)
	) u_oper_en (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(oper_en_wr),
		.wdata(cmd_wdata),
		.preset(status_preset),
		.mask(oper_en)
	);

	// Trigger enable mask
	sebk_enable_reg #(
		.WIDTH(WIDTH),
		.USED(`SEBK_TRIG_USED)
	) u_trig_en (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(trig_en_wr),
		.wdata(cmd_wdata),
		.preset(status_preset),
		.mask(trig_en)
	);

	// Arm enable mask
	sebk_enable_reg #(
		.WIDTH(WIDTH),
		.USED(`SEBK_ARM_USED)
	) u_arm_en (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(arm_en_wr),
		.wdata(cmd_wdata),
		.preset(status_preset),
		.mask(arm_en)
	);

	// Sequence enable mask
	sebk_enable_reg #(
		.WIDTH(WIDTH),
		.USED(`SEBK_SEQ_USED)
	) u_seq_en (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.wr(seq_en_wr),
		.wdata(cmd_wdata),
		.preset(status_preset),
		.mask(seq_en)
	);

	// Event contents as a bit pattern, picked before the clear lands
	always @*
	begin
		ev_mux = {WIDTH{1'b0}};
		case (cmd_sel)
			`SEBK_SEL_OPER_EV: ev_mux = oper_ev;
			`SEBK_SEL_TRIG_EV: ev_mux = trig_ev;
			`SEBK_SEL_ARM_EV: ev_mux = arm_ev;
			`SEBK_SEL_SEQ_EV: ev_mux = seq_ev;
			default: ev_mux = {WIDTH{1'b0}};
		endcase
	end

	// Enable contents as a bit pattern
	always @*
	begin
		en_mux = {WIDTH{1'b0}};
		case (cmd_sel)
			`SEBK_SEL_OPER_EN: en_mux = oper_en;
			`SEBK_SEL_TRIG_EN: en_mux = trig_en;
			`SEBK_SEL_ARM_EN: en_mux = arm_en;
			`SEBK_SEL_SEQ_EN: en_mux = seq_en;
			default: en_mux = {WIDTH{1'b0}};
		endcase
	end

	// Only one half is non-zero for any select, so an OR merges them
	assign rd_mux = ev_mux | en_mux;

	// Answer strobe: one cycle after each accepted command
	always @(posedge mclk)
	begin
		if (!rst_n)
			rsp_valid_r <= 1'b0;
		else if (ce)
			rsp_valid_r <= cmd_take;
	end

	// Refusal flag travels with the answer strobe
	always @(posedge mclk)
	begin
		if (!rst_n)
			rsp_error_r <= 1'b0;
		else if (ce)
			rsp_error_r <= wr_bad;
	end

	// Data holds until the next read, so writes leave it alone
	always @(posedge mclk)
	begin
		if (!rst_n)
			rsp_data_r <= {WIDTH{1'b0}};
		else if (rd_take)
			rsp_data_r <= rd_mux;
	end

	// Registered answer to the host
	assign rsp_valid = rsp_valid_r;
	assign rsp_error = rsp_error_r;
	assign rsp_data = rsp_data_r;
endmodule

// ### verification/sebk_checker_assertions.sv
// Purpose: port checker for the status event bank
// Assumes: ce is held high while commands run
// Notes: bound to the bank after the module
`timescale 1ns/100ps
`include "sebk_map.vh"
module sebk_checker #(
	parameter WIDTH = 16
) (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [2:0] cmd_sel,
	input wire [WIDTH-1:0] cmd_wdata,
	input wire rsp_valid,
	input wire rsp_error,
	input wire [WIDTH-1:0] rsp_data,
	input wire status_preset,
	input wire oper_summary,
	input wire trig_summary,
	input wire arm_summary,
	input wire seq_summary
);
	wire cmd_ok = ce && cmd_valid;

	// Bits that exist in each register pair
	function automatic [15:0] used_of(input [1:0] s);
		case (s)
			2'h0: used_of = `SEBK_OPER_USED;
			2'h3: used_of = `SEBK_SEQ_USED;
			default: used_of = `SEBK_TRIG_USED;
		endcase
	endfunction

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Answer timing and refusals
	a_rsp_next_cycle: assert property (cmd_ok |=> rsp_valid)
		else $error("no response after command");
	a_no_stray_rsp: assert property (ce && !cmd_valid |=> !rsp_valid)
		else $error("response without command");
	a_event_write_refused: assert property (cmd_ok && cmd_write && !cmd_sel[2]
		|=> rsp_error)
		else $error("event write not refused");
	a_error_only_refusal: assert property (cmd_ok && !(cmd_write && !cmd_sel[2])
		|=> !rsp_error)
		else $error("stray error flag");
	// Missing bits always read zero
	a_unused_read_zero: assert property (cmd_ok && !cmd_write
		|=> (rsp_data & ~used_of($past(cmd_sel[1:0]))) == 16'h0000)
		else $error("unused bit read as one");
	a_data_held: assert property (ce && !(cmd_valid && !cmd_write)
		|=> $stable(rsp_data))
		else $error("read data moved without read");
	sequence s_wr_rd;
		cmd_ok && cmd_write && cmd_sel[2] ##1 cmd_ok && !cmd_write && cmd_sel == $past(cmd_sel);
	endsequence
	a_enable_readback: assert property (s_wr_rd
		|=> rsp_data == ($past(cmd_wdata, 2) & used_of($past(cmd_sel[1:0]))))
		else $error("enable read differs from write");
	a_preset_masks: assert property (ce && status_preset && !cmd_valid
		|=> !(oper_summary || trig_summary || arm_summary || seq_summary))
		else $error("summary after preset");

	c_refused: cover property (cmd_ok && cmd_write && !cmd_sel[2]);
	c_readback: cover property (s_wr_rd);
	c_summary_up: cover property ($rose(oper_summary));
endmodule

bind sebk_status_bank sebk_checker #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.ce(ce), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
	.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
	.rsp_data(rsp_data), .status_preset(status_preset), .oper_summary(oper_summary),
	.trig_summary(trig_summary), .arm_summary(arm_summary), .seq_summary(seq_summary));

// ### verification/sebk_host_model.sv
// Purpose: host side of the command port
// Assumes: calls start just after a rising edge
// Notes: req leaves valid high so calls may run back to back
`timescale 1ns/100ps
module sebk_host_model (
	input wire mclk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [2:0] cmd_sel,
	output logic [15:0] cmd_wdata,
	input wire rsp_valid,
	input wire rsp_error,
	input wire [15:0] rsp_data
);
	logic [15:0] got;
	logic got_err;
	logic got_vld;

	// Quiet port at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_sel = 3'h0;
		cmd_wdata = 16'h0000;
	end

	// One command taken at the next edge; answer lands just after it
	// Write value is the plain sum of bit weights
	task automatic req(input logic w, input logic [2:0] s, input logic [15:0] d);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_sel = s;
		cmd_wdata = d;
		@(posedge mclk);
		#1;
		got = rsp_data;
		got_err = rsp_error;
		got_vld = rsp_valid;
	endtask

	// Idle cycle; scramble data so nothing relies on stale values
	task automatic idle;
		cmd_valid = 1'b0;
		cmd_wdata = ~cmd_wdata;
		@(posedge mclk);
		#1;
	endtask
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench for the status event bank
// Assumes: host model drives the command port
// Notes: one select vector serves all four registers
`timescale 1ns/100ps
module tb_top;
	logic mclk, rst_n, ce, clear_status, status_preset;
	logic [7:0] cond;
	logic [15:0] rise_sel, fall_sel;
	logic cmd_valid, cmd_write, rsp_valid, rsp_error;
	logic [2:0] cmd_sel;
	logic [15:0] cmd_wdata, rsp_data;
	logic [3:0] summ;
	int errors, cmp_count, cyc, i, m;
	logic [15:0] wt [8] = '{16'h0002, 16'h0020, 16'h0040, 16'h0400,
		16'h0002, 16'h0002, 16'h0002, 16'h0004};
	logic [2:0] rs [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
	logic [15:0] um [4] = '{16'h0462, 16'h0002, 16'h0002, 16'h0006};

	// Free running clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	sebk_status_bank #(.WIDTH(16)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.cond_settling(cond[0]), .cond_trig_wait(cond[1]), .cond_arm_wait(cond[2]),
		.cond_idle(cond[3]), .sequence_one_flag(cond[4]), .arm_sequence_flag(cond[5]),
		.layer_one_flag(cond[6]), .layer_two_flag(cond[7]),
		.oper_rise_select(rise_sel), .oper_falling_edge_select(fall_sel),
		.trig_rise_select(rise_sel), .trig_falling_edge_select(fall_sel),
		.arm_rise_select(rise_sel), .arm_falling_edge_select(fall_sel),
		.seq_rise_select(rise_sel), .seq_falling_edge_select(fall_sel),
		.clear_status(clear_status), .status_preset(status_preset),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
		.rsp_data(rsp_data), .oper_summary(summ[0]), .trig_summary(summ[1]),
		.arm_summary(summ[2]), .seq_summary(summ[3]));

	sebk_host_model u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_error(rsp_error), .rsp_data(rsp_data));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Read with answer and refusal flags checked
	task automatic rd(input logic [2:0] s, input logic [15:0] exp);
		u_host.req(1'b0, s, 16'h0000);
		u_host.idle();
		chk_bit(u_host.got_vld, 1'b1);
		chk_bit(u_host.got_err, 1'b0);
		chk(u_host.got, exp);
	endtask

	// Write; event registers must refuse it
	task automatic wr(input logic [2:0] s, input logic [15:0] d);
		u_host.req(1'b1, s, d);
		u_host.idle();
		chk_bit(u_host.got_err, ~s[2]);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard; the tests need well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors++;
			complete_run();
		end
	end

	initial
	begin
		ce = 1'b1;
		rst_n = 1'b0;
		clear_status = 1'b0;
		status_preset = 1'b0;
		cond = 8'h00;
		rise_sel = 16'hffff;
		fall_sel = 16'h0000;
		tick(5);
		rst_n = 1'b1;
		for (i = 4; i < 8; i++)
			rd(i[2:0], 16'h0000);
		$display("test reset done");
		// Masks keep only existing bits; write then read back to back
		for (i = 0; i < 4; i++)
		begin
			wr(i[2:0], 16'hffff);
			wr(i[2:0] + 3'h4, 16'hffff);
			rd(i[2:0] + 3'h4, um[i]);
			u_host.req(1'b1, i[2:0] + 3'h4, 16'h0000);
			u_host.req(1'b0, i[2:0] + 3'h4, 16'h0000);
			u_host.idle();
			chk(u_host.got, 16'h0000);
			// Leave every mask open so all four summaries can be watched
			wr(i[2:0] + 3'h4, um[i]);
		end
		$display("test enables done");
		// Each condition in turn, rising then falling selection
		for (m = 0; m < 2; m++)
		begin
			rise_sel = {16{m == 0}};
			fall_sel = {16{m == 1}};
			for (i = 0; i < 8; i++)
			begin
				cond[i] = 1'b1;
				tick(2);
				chk_bit(summ[rs[i]], m == 0);
				rd(rs[i], m ? 16'h0000 : wt[i]);
				cond[i] = 1'b0;
				tick(2);
				chk_bit(summ[rs[i]], m == 1);
				rd(rs[i], m ? wt[i] : 16'h0000);
				rd(rs[i], 16'h0000);
				chk_bit(summ[rs[i]], 1'b0);
			end
		end
		$display("test edges done");
		// Frozen while ce is low: no answer, and a pulse inside is never seen
		ce = 1'b0;
		cond[0] = 1'b1;
		u_host.req(1'b0, 3'h0, 16'h0000);
		u_host.idle();
		chk_bit(u_host.got_vld, 1'b0);
		ce = 1'b1;
		cond[0] = 1'b0;
		tick(1);
		rd(3'h0, 16'h0000);
		$display("test freeze done");
		// Latched idle event against the mask, then clear and preset
		rise_sel = 16'hffff;
		fall_sel = 16'h0000;
		cond[3] = 1'b1;
		tick(2);
		cond[3] = 1'b0;
		tick(2);
		wr(3'h4, 16'h0002);
		chk_bit(summ[0], 1'b0);
		wr(3'h4, 16'h0400);
		chk_bit(summ[0], 1'b1);
		clear_status = 1'b1;
		tick(1);
		clear_status = 1'b0;
		chk_bit(summ[0], 1'b0);
		rd(3'h4, 16'h0400);
		// Raise the summary again so the preset has something to drop
		cond[3] = 1'b1;
		tick(2);
		chk_bit(summ[0], 1'b1);
		status_preset = 1'b1;
		tick(1);
		status_preset = 1'b0;
		chk_bit(summ[0], 1'b0);
		rd(3'h4, 16'h0000);
		rd(3'h0, 16'h0400);
		cond[3] = 1'b0;
		$display("test summary done");
		complete_run();
	end
endmodule
